// file: core/pmsp_mgmt_port.sv
// Management serial port: two-wire target, power sequencing and software register port
//
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/1ns
module pmsp_mgmt_port
  import pmsp_pkg::*;
#(
  parameter int INIT_CYCLES = pmsp_pkg::INIT_CYCLES_DEF,
  parameter int ON_DELAY_CYCLES = pmsp_pkg::ON_DELAY_CYCLES_DEF
) (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire pmsp_pkg::pmsp_swreq_s sw_req_in,
  output logic [pmsp_pkg::DW-1:0] sw_rdata_out,
  output logic irq_out,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_out,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic [3:0] address_strap_pin_in,
  input wire logic vin_ok_in,
  input wire logic remote_enable_pin_in,
  input wire logic soft_start_done_in,
  input wire logic fault_in,
  output logic output_enable_out,
  output logic power_good_pin_out,
  output logic power_good_pin_oe_out
);
  import pmsp_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [9:0] pins_s;
  logic scl_s, sda_s, vin_s, ren_s, ss_s, flt_s;
  logic [3:0] strap_s;
  logic scl_p_q, sda_p_q;
  logic scl_rise, scl_fall, bus_start, bus_stop;

  pmsp_sync #(.W(10)) u_sync (
    .ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .async_in({scl_in, sda_in, vin_ok_in, remote_enable_pin_in, soft_start_done_in,
               fault_in, address_strap_pin_in}),
    .sync_out(pins_s)
  );
  assign {scl_s, sda_s, vin_s, ren_s, ss_s, flt_s, strap_s} = pins_s;

  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  // Sampling at 25 MHz leaves dozens of samples per bit even at 400 kHz
  assign scl_rise = scl_s & ~scl_p_q;
  assign scl_fall = ~scl_s & scl_p_q;
  assign bus_start = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign bus_stop = scl_s & scl_p_q & ~sda_p_q & sda_s;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Returns {valid, slot} for a readable command
  function automatic logic [4:0] cmd_slot(input logic [7:0] c);
    case (c)
      CMD_STATUS_BYTE, CMD_STATUS_WORD: cmd_slot = {1'b1, IDX_STATUS_WORD};
      CMD_STATUS_VOUT: cmd_slot = {1'b1, IDX_STATUS_VOUT};
      CMD_STATUS_IOUT: cmd_slot = {1'b1, IDX_STATUS_IOUT};
      CMD_STATUS_INPUT: cmd_slot = {1'b1, IDX_STATUS_INPUT};
      CMD_STATUS_TEMPERATURE: cmd_slot = {1'b1, IDX_STATUS_TEMPERATURE};
      CMD_STATUS_CML: cmd_slot = {1'b1, IDX_STATUS_CML};
      CMD_STATUS_MFR_SPECIFIC: cmd_slot = {1'b1, IDX_STATUS_MFR_SPECIFIC};
      CMD_READ_VIN: cmd_slot = {1'b1, IDX_READ_VIN};
      CMD_READ_VOUT: cmd_slot = {1'b1, IDX_READ_VOUT};
      CMD_READ_IOUT: cmd_slot = {1'b1, IDX_READ_IOUT};
      CMD_READ_TEMPERATURE_1: cmd_slot = {1'b1, IDX_READ_TEMPERATURE_1};
      default: cmd_slot = 5'h00;
    endcase
  endfunction

  function automatic logic is_status(input logic [7:0] c);
    is_status = (c == CMD_STATUS_BYTE) || (c == CMD_STATUS_WORD);
  endfunction

  // ----------------------------------------------------------------
  // Strap capture and power sequencing
  // ----------------------------------------------------------------
  pmsp_pwr_e pst_q, pst_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [1:0] settle_q, settle_d;
  logic strap_done_q, strap_done_d;
  logic [6:0] addr_q, addr_d;
  logic oe_q, oe_d, pg_q, pg_d;

  always_comb begin
    pst_d = pst_q;
    cnt_d = cnt_q + CNT_W'(1);
    settle_d = settle_q;
    strap_done_d = strap_done_q;
    addr_d = addr_q;
    // Captured once; nothing but reset clears the done flag
    if (!strap_done_q) begin
      if (settle_q == STRAP_SETTLE) begin
        strap_done_d = 1'b1;
        addr_d = ADDR_BASE + {3'h0, strap_s};
      end else begin
        settle_d = settle_q + 2'h1;
      end
    end
    case (pst_q)
      P_OFF: begin
        cnt_d = '0;
        if (vin_s) begin
          pst_d = P_INIT;
        end
      end
      P_INIT: begin
        if (cnt_q == CNT_W'(INIT_CYCLES - 1)) begin
          pst_d = P_READY;
        end
      end
      P_READY: begin
        cnt_d = '0;
        if (ren_s) begin
          pst_d = P_DELAY;
        end
      end
      P_DELAY: begin
        if (cnt_q == CNT_W'(ON_DELAY_CYCLES - 1)) begin
          pst_d = P_RAMP;
        end
      end
      P_RAMP: begin
        if (ss_s) begin
          pst_d = P_ON;
        end
      end
      P_ON: pst_d = P_ON;
      P_LATCH: pst_d = P_LATCH;
      default: pst_d = P_OFF;
    endcase
    // Faults latch off until the remote enable or the input voltage is withdrawn
    if ((pst_q == P_RAMP || pst_q == P_ON) && flt_s) begin
      pst_d = P_LATCH;
    end
    if ((pst_q == P_DELAY || pst_q == P_RAMP || pst_q == P_ON || pst_q == P_LATCH) && !ren_s) begin
      pst_d = P_READY;
    end
    if (!vin_s) begin
      pst_d = P_OFF;
    end
    oe_d = (pst_d == P_RAMP) || (pst_d == P_ON);
    pg_d = (pst_d == P_ON) && !flt_s;
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      pst_q <= P_OFF;
      cnt_q <= '0;
      settle_q <= 2'h0;
      strap_done_q <= 1'b0;
      addr_q <= 7'h00;
      oe_q <= 1'b0;
      pg_q <= 1'b0;
    end else begin
      pst_q <= pst_d;
      cnt_q <= cnt_d;
      settle_q <= settle_d;
      strap_done_q <= strap_done_d;
      addr_q <= addr_d;
      oe_q <= oe_d;
      pg_q <= pg_d;
    end
  end

  // ----------------------------------------------------------------
  // Two-wire target
  // ----------------------------------------------------------------
  pmsp_bus_e bst_q, bst_d;
  logic [2:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d, cmd_q, cmd_d;
  logic rw_q, rw_d, cmdv_q, cmdv_d, wcnt_q, wcnt_d;
  logic [DW-1:0] wdat_q, wdat_d, tx_q, tx_d, tx_word;
  logic drv_q, drv_d, ackd_q, ackd_d, bref_q, bref_d, busy_q, busy_d;
  logic ev_done, ev_store, ev_busy, ev_clear;
  logic [7:0] byte_in;
  logic [4:0] slot;
  logic [DW-1:0] mem_rdata;
  logic ctrl_busy;

  assign byte_in = {sh_q[6:0], sda_s};
  assign slot = cmd_slot(cmd_q);

  // Status overlays carry live flags on top of the stored word
  always_comb begin
    tx_word = slot[4] ? mem_rdata : '0;
    if (is_status(cmd_q)) begin
      tx_word[STB_BUSY_BIT] = busy_q;
      tx_word[STW_PG_N_BIT] = ~pg_q;
    end
  end

  always_comb begin
    bst_d = bst_q;
    bit_d = bit_q;
    sh_d = sh_q;
    cmd_d = cmd_q;
    rw_d = rw_q;
    cmdv_d = cmdv_q;
    wcnt_d = wcnt_q;
    wdat_d = wdat_q;
    tx_d = tx_q;
    drv_d = drv_q;
    ackd_d = ackd_q;
    bref_d = bref_q;
    busy_d = busy_q;
    ev_done = 1'b0;
    ev_store = 1'b0;
    ev_busy = 1'b0;
    ev_clear = 1'b0;
    if (bus_start) begin
      bst_d = B_ADDR;
      bit_d = 3'h0;
      drv_d = 1'b0;
    end else if (bus_stop) begin
      if (cmdv_q && !rw_q && !bref_q && bst_q != B_SKIP) begin
        ev_done = 1'b1;
        if (cmd_q == CMD_CLEAR_FAULTS) begin
          ev_clear = 1'b1;
          busy_d = 1'b0;
        end
        ev_store = (cmd_q == CMD_STORE_DEFAULT_ALL) || (cmd_q == CMD_STORE_USER_ALL);
      end
      bst_d = B_IDLE;
      cmdv_d = 1'b0;
      drv_d = 1'b0;
    end else begin
      case (bst_q)
        B_ADDR, B_CMD, B_WDAT: begin
          if (scl_rise) begin
            sh_d = byte_in;
            bit_d = bit_q + 3'h1;
            if (bit_q == 3'h7) begin
              if (bst_q == B_ADDR) begin
                rw_d = byte_in[0];
                bst_d = (strap_done_q && byte_in[7:1] == addr_q) ? B_AACK : B_SKIP;
              end else if (bst_q == B_CMD) begin
                cmd_d = byte_in;
                cmdv_d = 1'b1;
                wcnt_d = 1'b0;
                bref_d = ctrl_busy;
                if (ctrl_busy) begin
                  busy_d = 1'b1;
                  ev_busy = 1'b1;
                end
                bst_d = B_CACK;
              end else begin
                if (wcnt_q) begin
                  wdat_d[15:8] = byte_in;
                end else begin
                  wdat_d[7:0] = byte_in;
                end
                wcnt_d = 1'b1;
                bst_d = B_DACK;
              end
            end
          end
        end
        B_AACK, B_CACK, B_DACK: begin
          if (scl_fall) begin
            drv_d = ~drv_q;
            bit_d = 3'h0;
            if (drv_q) begin
              if (bst_q == B_AACK && rw_q) begin
                bst_d = B_RLOAD;
              end else if (bst_q == B_AACK && !cmdv_q) begin
                bst_d = B_CMD;
              end else begin
                bst_d = B_WDAT;
              end
            end
          end
        end
        B_RLOAD: begin
          drv_d = ~tx_word[7];
          tx_d = {tx_word[6:0], tx_word[15:8], 1'b0};
          bst_d = B_RDAT;
        end
        B_RDAT: begin
          if (scl_rise) begin
            bit_d = bit_q + 3'h1;
            if (bit_q == 3'h7) begin
              bst_d = B_RACK;
              ackd_d = 1'b0;
            end
          end else if (scl_fall) begin
            drv_d = ~tx_q[15];
            tx_d = {tx_q[14:0], 1'b0};
          end
        end
        B_RACK: begin
          if (scl_fall) begin
            if (ackd_q) begin
              drv_d = ~tx_q[15];
              tx_d = {tx_q[14:0], 1'b0};
              ackd_d = 1'b0;
              bst_d = B_RDAT;
            end else begin
              drv_d = 1'b0;
            end
          end else if (scl_rise) begin
            ackd_d = ~sda_s;
            if (sda_s) begin
              bst_d = B_SKIP;
            end
          end
        end
        B_IDLE, B_SKIP: bst_d = bst_q;
        default: bst_d = B_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      bst_q <= B_IDLE;
      bit_q <= 3'h0;
      sh_q <= 8'h00;
      cmd_q <= 8'h00;
      rw_q <= 1'b0;
      cmdv_q <= 1'b0;
      wcnt_q <= 1'b0;
      wdat_q <= '0;
      tx_q <= '0;
      drv_q <= 1'b0;
      ackd_q <= 1'b0;
      bref_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      bst_q <= bst_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      cmd_q <= cmd_d;
      rw_q <= rw_d;
      cmdv_q <= cmdv_d;
      wcnt_q <= wcnt_d;
      wdat_q <= wdat_d;
      tx_q <= tx_d;
      drv_q <= drv_d;
      ackd_q <= ackd_d;
      bref_q <= bref_d;
      busy_q <= busy_d;
    end
  end

  // Clock held low for the one cycle the read word takes to settle
  assign scl_oe_out = (bst_q == B_RLOAD);
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign sda_oe_out = drv_q;

  // ----------------------------------------------------------------
  // Software registers and interrupt
  // ----------------------------------------------------------------
  logic ctrl_q, ctrl_d;
  logic [IRQ_W-1:0] irq_q, irq_d, mask_q, mask_d, ev_vec;
  logic [DW-1:0] rdat_q, rdat_d;
  logic mem_we;

  assign ctrl_busy = ctrl_q;
  assign ev_vec = {ev_clear, ev_busy, ev_store, ev_done};
  assign mem_we = sw_req_in.wr & sw_req_in.addr[OFS_MEM_BIT];

  pmsp_regmem #(.AW(MEM_AW), .W(DW)) u_mem (
    .ref_clk_in(ref_clk_in),
    .we_in(mem_we),
    .waddr_in(sw_req_in.addr[MEM_AW-1:0]),
    .wdata_in(sw_req_in.wdata),
    .raddr_in(slot[3:0]),
    .rdata_out(mem_rdata)
  );

  always_comb begin
    ctrl_d = ctrl_q;
    mask_d = mask_q;
    irq_d = irq_q;
    rdat_d = '0;
    if (sw_req_in.wr && sw_req_in.addr == OFS_CTRL) begin
      ctrl_d = sw_req_in.wdata[CTRL_BUSY_BIT];
    end
    if (sw_req_in.wr && sw_req_in.addr == OFS_IRQ_MASK) begin
      mask_d = sw_req_in.wdata[IRQ_W-1:0];
    end
    if (sw_req_in.rd) begin
      case (sw_req_in.addr)
        OFS_CTRL: rdat_d = {15'h0000, ctrl_q};
        OFS_STATE: rdat_d = {2'h0, pst_q, pg_q, oe_q, busy_q, strap_done_q, addr_q};
        OFS_IRQ_STAT: begin
          rdat_d = {12'h000, irq_q};
          irq_d = '0;
        end
        OFS_IRQ_MASK: rdat_d = {12'h000, mask_q};
        OFS_LAST_CMD: rdat_d = {8'h00, cmd_q};
        OFS_LAST_DATA: rdat_d = wdat_q;
        default: rdat_d = '0;
      endcase
    end
    // A new event wins over a clearing read in the same cycle
    irq_d = irq_d | ev_vec;
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      ctrl_q <= 1'b0;
      mask_q <= '0;
      irq_q <= '0;
      rdat_q <= '0;
    end else begin
      ctrl_q <= ctrl_d;
      mask_q <= mask_d;
      irq_q <= irq_d;
      rdat_q <= rdat_d;
    end
  end

  assign sw_rdata_out = rdat_q;
  assign irq_out = |(irq_q & mask_q);
  assign output_enable_out = oe_q;
  assign power_good_pin_out = 1'b0;
  assign power_good_pin_oe_out = ~pg_q;
endmodule

// file: core/pmsp_pkg.sv
// Shared constants, types and register map of the power module management serial port
package pmsp_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 25;
  localparam int T_INIT_MS = 30;
  localparam int T_ON_DELAY_MS = 5;
  localparam int INIT_CYCLES_DEF = T_INIT_MS * 1000 * CLK_MHZ;
  localparam int ON_DELAY_CYCLES_DEF = T_ON_DELAY_MS * 1000 * CLK_MHZ;
  localparam int CNT_W = 24;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  // ----------------------------------------------------------------
  // Bus addressing and command codes
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_BASE = 7'h20;
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_STORE_DEFAULT_ALL = 8'h11;
  localparam logic [7:0] CMD_STORE_USER_ALL = 8'h15;
  localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
  localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
  localparam logic [7:0] CMD_STATUS_VOUT = 8'h7a;
  localparam logic [7:0] CMD_STATUS_IOUT = 8'h7b;
  localparam logic [7:0] CMD_STATUS_INPUT = 8'h7c;
  localparam logic [7:0] CMD_STATUS_TEMPERATURE = 8'h7d;
  localparam logic [7:0] CMD_STATUS_CML = 8'h7e;
  localparam logic [7:0] CMD_STATUS_MFR_SPECIFIC = 8'h80;
  localparam logic [7:0] CMD_READ_VIN = 8'h88;
  localparam logic [7:0] CMD_READ_VOUT = 8'h8b;
  localparam logic [7:0] CMD_READ_IOUT = 8'h8c;
  localparam logic [7:0] CMD_READ_TEMPERATURE_1 = 8'h8d;
  localparam int STB_BUSY_BIT = 7;
  localparam int STW_PG_N_BIT = 11;

  // ----------------------------------------------------------------
  // Telemetry and status memory slots
  // ----------------------------------------------------------------
  localparam int MEM_AW = 4;
  localparam int DW = 16;
  localparam logic [3:0] IDX_STATUS_WORD = 4'h0;
  localparam logic [3:0] IDX_STATUS_VOUT = 4'h1;
  localparam logic [3:0] IDX_STATUS_IOUT = 4'h2;
  localparam logic [3:0] IDX_STATUS_INPUT = 4'h3;
  localparam logic [3:0] IDX_STATUS_TEMPERATURE = 4'h4;
  localparam logic [3:0] IDX_STATUS_CML = 4'h5;
  localparam logic [3:0] IDX_STATUS_MFR_SPECIFIC = 4'h6;
  localparam logic [3:0] IDX_READ_VIN = 4'h7;
  localparam logic [3:0] IDX_READ_VOUT = 4'h8;
  localparam logic [3:0] IDX_READ_IOUT = 4'h9;
  localparam logic [3:0] IDX_READ_TEMPERATURE_1 = 4'ha;

  // ----------------------------------------------------------------
  // Software register map
  // ----------------------------------------------------------------
  localparam int SW_AW = 5;
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_STATE = 5'h01;
  localparam logic [4:0] OFS_IRQ_STAT = 5'h02;
  localparam logic [4:0] OFS_IRQ_MASK = 5'h03;
  localparam logic [4:0] OFS_LAST_CMD = 5'h04;
  localparam logic [4:0] OFS_LAST_DATA = 5'h05;
  localparam int OFS_MEM_BIT = 4;
  localparam int CTRL_BUSY_BIT = 0;
  localparam int IRQ_W = 4;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_STORE = 1;
  localparam int IRQ_BUSY = 2;
  localparam int IRQ_CLEAR = 3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    B_IDLE, B_ADDR, B_AACK, B_CMD, B_CACK, B_WDAT, B_DACK, B_RLOAD, B_RDAT, B_RACK, B_SKIP
  } pmsp_bus_e;

  typedef enum logic [2:0] {
    P_OFF, P_INIT, P_READY, P_DELAY, P_RAMP, P_ON, P_LATCH
  } pmsp_pwr_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [SW_AW-1:0] addr;
    logic [DW-1:0] wdata;
  } pmsp_swreq_s;

endpackage

// file: core/pmsp_regmem.sv
// Telemetry and status word memory, one write port and a registered read port
`timescale 1ns/1ns
module pmsp_regmem #(
  parameter int AW = 4,
  parameter int W = 16
) (
  input wire logic ref_clk_in,
  input wire logic we_in,
  input wire logic [AW-1:0] waddr_in,
  input wire logic [W-1:0] wdata_in,
  input wire logic [AW-1:0] raddr_in,
  output logic [W-1:0] rdata_out
);
  logic [W-1:0] mem_q [2**AW];
  logic [W-1:0] rdata_q;

  // No reset: contents are undefined until software loads them
  always_ff @(posedge ref_clk_in) begin
    if (we_in) begin
      mem_q[waddr_in] <= wdata_in;
    end
    rdata_q <= mem_q[raddr_in];
  end

  assign rdata_out = rdata_q;
endmodule

// file: core/pmsp_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module pmsp_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // Reset value of ones keeps idle bus lines released
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      meta_q <= '1;
      sync_q <= '1;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule

// file: tb/pmsp_host_model.sv
// Two-wire bus host that stands on the far side of the port
`timescale 1ns/1ns
module pmsp_host_model (
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_pull_out,
  output logic sda_pull_out
);
  localparam int QTR = 80;
  initial begin
    scl_pull_out = 1'b0;
    sda_pull_out = 1'b0;
  end
  // One bit slot; the high phase waits for the device to let the clock go
  task automatic bit_io(input logic b, output logic r);
    sda_pull_out = ~b;
    #QTR scl_pull_out = 1'b0;
    wait (scl_in === 1'b1);
    #QTR r = sda_in;
    #QTR scl_pull_out = 1'b1;
    #QTR;
  endtask
  task automatic start();
    sda_pull_out = 1'b0;
    #QTR scl_pull_out = 1'b0;
    wait (scl_in === 1'b1);
    #QTR sda_pull_out = 1'b1;
    #QTR scl_pull_out = 1'b1;
    #QTR;
  endtask
  task automatic stop();
    sda_pull_out = 1'b1;
    #QTR scl_pull_out = 1'b0;
    wait (scl_in === 1'b1);
    #QTR sda_pull_out = 1'b0;
    #(4 * QTR);
  endtask
  // Byte plus acknowledge slot; no checksum byte is ever added or expected
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q,
                      output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(a, ack);
  endtask
endmodule

// file: tb/pmsp_mgmt_port_assertions.sv
// Concurrent checks on the pins of the management serial port
`timescale 1ns/1ns
module pmsp_mgmt_port_assertions
  import pmsp_pkg::*;
#(
  parameter int INIT_CYCLES = 40,
  parameter int ON_DELAY_CYCLES = 20
) (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic scl_oe_out,
  input wire logic sda_oe_out,
  input wire logic vin_ok_in,
  input wire logic remote_enable_pin_in,
  input wire logic soft_start_done_in,
  input wire logic fault_in,
  input wire logic output_enable_out,
  input wire logic power_good_pin_oe_out
);
  // ----------------------------------------------------------------
  // Time since input voltage and remote enable rose
  // ----------------------------------------------------------------
  // Raw pins lead the synchronised ones, so these counts can only run ahead
  int vin_cnt_q, vin_cnt_d, ren_cnt_q, ren_cnt_d;
  always_comb begin
    vin_cnt_d = vin_ok_in ? vin_cnt_q + int'(vin_cnt_q < 1000000) : 0;
    ren_cnt_d = remote_enable_pin_in ? ren_cnt_q + int'(ren_cnt_q < 1000000) : 0;
  end
  always_ff @(posedge ref_clk_in) begin
    vin_cnt_q <= rstn_in ? vin_cnt_d : 0;
    ren_cnt_q <= rstn_in ? ren_cnt_d : 0;
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  sequence s_fault_held;
    fault_in [*4];
  endsequence
  sequence s_ramping;
    !soft_start_done_in [*4];
  endsequence
  a_pg_fault_low: assert property (s_fault_held |=> power_good_pin_oe_out)
    else $error("power good released during a fault");
  a_pg_ramp_low: assert property (s_ramping |=> power_good_pin_oe_out)
    else $error("power good released before soft start end");
  a_pg_needs_on: assert property (!output_enable_out [*2] |-> power_good_pin_oe_out)
    else $error("power good released with output off");
  a_total_delay: assert property ($rose(output_enable_out) |->
    vin_cnt_q >= INIT_CYCLES + ON_DELAY_CYCLES) else $error("output on too early after input");
  a_remote_delay: assert property ($rose(output_enable_out) |->
    ren_cnt_q >= ON_DELAY_CYCLES) else $error("output on too early after enable");
  a_vin_gone_off: assert property (!vin_ok_in [*4] |=> !output_enable_out)
    else $error("output on without input voltage");
  a_stretch_short: assert property ($rose(scl_oe_out) |-> ##[1:4] !scl_oe_out)
    else $error("clock held low too long");
  a_strap_wait: assert property ($rose(rstn_in) |-> !sda_oe_out [*4])
    else $error("data line driven before the strap was taken");
endmodule

bind pmsp_mgmt_port pmsp_mgmt_port_assertions #(
  .INIT_CYCLES(INIT_CYCLES),
  .ON_DELAY_CYCLES(ON_DELAY_CYCLES)
) u_chk (
  .ref_clk_in,
  .rstn_in,
  .scl_oe_out,
  .sda_oe_out,
  .vin_ok_in,
  .remote_enable_pin_in,
  .soft_start_done_in,
  .fault_in,
  .output_enable_out,
  .power_good_pin_oe_out
);

// file: tb/power_module_mgmt_serial_port_test.sv
// Self-checking bench of the management serial port
`timescale 1ns/1ns
module power_module_mgmt_serial_port_test;
  import pmsp_pkg::*;
  localparam int INIT = 40;
  localparam int OND = 20;
  logic ref_clk_in, rstn_in, vin_ok, ren, ssd, fault, irq, scl_oe, sda_oe, oen, pg_oe;
  logic scl_pull, sda_pull;
  logic [3:0] strap;
  logic [6:0] addr, oth;
  logic [15:0] rdata, mem [11];
  logic [31:0] seed;
  pmsp_swreq_s req;
  int bad_count, n_checks;
  wire scl_w = ~(scl_pull | scl_oe);
  wire sda_w = ~(sda_pull | sda_oe);
  logic [7:0] cmds [12] = '{CMD_STATUS_WORD, CMD_STATUS_VOUT, CMD_STATUS_IOUT,
    CMD_STATUS_INPUT, CMD_STATUS_TEMPERATURE, CMD_STATUS_CML, CMD_STATUS_MFR_SPECIFIC,
    CMD_READ_VIN, CMD_READ_VOUT, CMD_READ_IOUT, CMD_READ_TEMPERATURE_1, CMD_STATUS_BYTE};
  pmsp_mgmt_port #(.INIT_CYCLES(INIT), .ON_DELAY_CYCLES(OND)) DUT (
    .ref_clk_in, .rstn_in, .sw_req_in(req), .sw_rdata_out(rdata), .irq_out(irq),
    .scl_in(scl_w), .scl_out(), .scl_oe_out(scl_oe), .sda_in(sda_w), .sda_out(),
    .sda_oe_out(sda_oe), .address_strap_pin_in(strap), .vin_ok_in(vin_ok),
    .remote_enable_pin_in(ren), .soft_start_done_in(ssd), .fault_in(fault),
    .output_enable_out(oen), .power_good_pin_out(), .power_good_pin_oe_out(pg_oe));
  pmsp_host_model host (.scl_in(scl_w), .sda_in(sda_w), .scl_pull_out(scl_pull),
    .sda_pull_out(sda_pull));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    n_checks++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic chk_win(input string n, input int lo, input int hi, input int s);
    n_checks++;
    if (s < lo || s > hi) begin
      bad_count++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", n, lo, hi, s);
    end
  endtask
  // Each access leaves one idle cycle so a strobe is never set twice in a step
  task automatic sw_wr(input logic [4:0] a, input logic [15:0] d);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge ref_clk_in);
    req <= '0;
    @(posedge ref_clk_in);
  endtask
  task automatic sw_rd(input logic [4:0] a, output logic [15:0] d);
    req <= '{1'b0, 1'b1, a, 16'h0};
    @(posedge ref_clk_in);
    req <= '0;
    #1 d = rdata;
    @(posedge ref_clk_in);
  endtask
  task automatic wait_oen(input logic v, output int n);
    n = 0;
    while (oen !== v && n < 300) begin
      @(posedge ref_clk_in) #1;
      n++;
    end
  endtask
  task automatic bus_wr(input logic [6:0] a, input logic [7:0] c, output logic ack);
    logic [7:0] q;
    logic k;
    host.start();
    host.xfer({a, 1'b0}, 1'b1, q, ack);
    if (ack === 1'b0) host.xfer(c, 1'b1, q, k);
    host.stop();
    @(posedge ref_clk_in);
  endtask
  task automatic bus_rd(input logic [7:0] c, input int n, output logic [15:0] w);
    logic [7:0] q;
    logic k;
    w = 16'h0;
    host.start();
    host.xfer({addr, 1'b0}, 1'b1, q, k);
    host.xfer(c, 1'b1, q, k);
    host.start();
    host.xfer({addr, 1'b1}, 1'b1, q, k);
    host.xfer(8'hff, (n == 1), w[7:0], k);
    if (n == 2) host.xfer(8'hff, 1'b1, w[15:8], k);
    host.stop();
    @(posedge ref_clk_in);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Clock, watchdog and scenarios
  // ----------------------------------------------------------------
  initial begin
    ref_clk_in = 1'b0;
    forever #20 ref_clk_in = ~ref_clk_in;
  end
  initial begin
    #3000000;
    bad_count++;
    complete_run();
  end
  initial begin
    logic ack;
    logic [3:0] v;
    logic [15:0] w;
    int n;
    seed = 32'h3e43;
    bad_count = 0;
    n_checks = 0;
    rstn_in = 1'b0;
    req = '0;
    {vin_ok, ren, ssd, fault} = 4'h0;
    strap = 4'(rnd());
    addr = 7'h20 + 7'(strap);
    repeat (5) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    repeat (8) @(posedge ref_clk_in);
    v = strap ^ (4'(rnd()) | 4'h1);
    strap <= v;
    oth = 7'h20 + 7'(v);
    bus_wr(oth, CMD_CLEAR_FAULTS, ack);
    chk("other address", 16'(ack), 16'h1);
    bus_wr(addr, CMD_CLEAR_FAULTS, ack);
    chk("strapped address", 16'(ack), 16'h0);
    sw_rd(OFS_STATE, w);
    chk("state address", {9'h0, w[6:0]}, {9'h0, addr});
    chk("pg before", 16'(pg_oe), 16'h1);
    vin_ok <= 1'b1;
    ren <= 1'b1;
    wait_oen(1'b1, n);
    chk_win("input delay", INIT + OND, INIT + OND + 8, n);
    repeat (4) @(posedge ref_clk_in);
    chk("pg ramp", 16'(pg_oe), 16'h1);
    ssd <= 1'b1;
    repeat (6) @(posedge ref_clk_in);
    chk("pg good", 16'(pg_oe), 16'h0);
    for (int i = 0; i < 11; i++) begin
      mem[i] = 16'(rnd()) & 16'hf77f;
      sw_wr(5'h10 + 5'(i), mem[i]);
    end
    for (int i = 0; i < 12; i++) begin
      n = (i == 0 || (i > 6 && i < 11)) ? 2 : 1;
      bus_rd(cmds[i], n, w);
      chk("readback", w, n == 2 ? mem[i % 11] : {8'h0, mem[i % 11][7:0]});
    end
    fault <= 1'b1;
    repeat (6) @(posedge ref_clk_in);
    chk("pg fault", 16'(pg_oe), 16'h1);
    {ren, ssd, fault} <= 3'h0;
    wait_oen(1'b0, n);
    repeat (6) @(posedge ref_clk_in);
    ren <= 1'b1;
    wait_oen(1'b1, n);
    chk_win("enable delay", OND, OND + 8, n);
    sw_wr(OFS_IRQ_MASK, 16'hf);
    sw_rd(OFS_IRQ_STAT, w);
    sw_wr(OFS_CTRL, 16'h1);
    bus_wr(addr, CMD_CLEAR_FAULTS, ack);
    chk("irq raised", 16'(irq), 16'h1);
    sw_wr(OFS_CTRL, 16'h0);
    bus_rd(CMD_STATUS_BYTE, 1, w);
    chk("busy flag", 16'(w[STB_BUSY_BIT]), 16'h1);
    sw_rd(OFS_IRQ_STAT, w);
    chk("busy event", 16'(w[IRQ_BUSY]), 16'h1);
    repeat (2) @(posedge ref_clk_in);
    chk("irq cleared", 16'(irq), 16'h0);
    sw_wr(OFS_IRQ_MASK, 16'h0);
    bus_wr(addr, CMD_CLEAR_FAULTS, ack);
    chk("irq masked", 16'(irq), 16'h0);
    sw_rd(OFS_IRQ_STAT, w);
    chk("clear event", 16'(w[IRQ_CLEAR]), 16'h1);
    bus_rd(CMD_STATUS_BYTE, 1, w);
    chk("busy gone", 16'(w[STB_BUSY_BIT]), 16'h0);
    sw_rd(5'h0f, w);
    chk("unmapped", w, 16'h0);
    sw_rd(5'h12, w);
    chk("write only", w, 16'h0);
    // Store goes last: only the read of its interrupt status event follows it
    bus_wr(addr, CMD_STORE_USER_ALL, ack);
    sw_rd(OFS_IRQ_STAT, w);
    chk("store event", 16'(w[IRQ_STORE]), 16'h1);
    complete_run();
  end
endmodule
